// ### common/pms_pkg.sv
// shared constants and types of the phy management serial controller
package pms_pkg;

    // register map
    localparam logic [7:0]  CMD_OFS      = 8'h10;
    localparam int          MSB_LANE     = 3;
    localparam logic [31:0] CMD_RESET    = 32'h0000_0000;

    // opcode and frame patterns
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_READ      = 2'h2;
    localparam logic [1:0]  START_PAT    = 2'h1;
    localparam logic [1:0]  TA_PAT       = 2'h2;
    localparam logic [31:0] PREAMBLE     = 32'hFFFF_FFFF;

    // bit slot counts of a frame
    localparam logic [6:0]  WRITE_BITS   = 7'h40;
    localparam logic [6:0]  READ_DRIVE   = 7'h2E;
    localparam logic [6:0]  READ_BITS    = 7'h3F;

    // management clock timing
    localparam int          CLK_KHZ      = 40000;
    localparam int          MDC_MAX_KHZ  = 2500;
    localparam int          MDC_HALF     = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);

    typedef struct packed {
        logic [1:0]  rsvd;
        logic        done_irq_enable;
        logic        ready;
        logic [1:0]  op;
        logic [4:0]  target_phy_sel;
        logic [4:0]  target_reg_sel;
        logic [15:0] data;
    } pms_cmd_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pms_csr_req_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SHIFT  = 2'h1,
        ST_FINISH = 2'h2
    } pms_state_type;

endpackage

// ### hdl/pms_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module pms_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,    // system clock
    input  wire logic             nrst,   // async reset, active low
    input  wire logic [WIDTH-1:0] d,      // asynchronous input
    output logic      [WIDTH-1:0] q       // synchronised output
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ### hdl/pms_mdc_gen.sv
// management clock divider with edge strobes
`timescale 1ns/1ps
module pms_mdc_gen #(
    parameter int HALF = pms_pkg::MDC_HALF
) (
    input  wire logic clk,    // system clock
    input  wire logic nrst,   // async reset, active low
    input  wire logic run,    // clock runs while high
    output logic      mdc,    // management clock out
    output logic      rise,   // pulse before mdc goes high
    output logic      fall    // pulse before mdc goes low
);

    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt;
    wire           wrap = run && (cnt == LAST);

    assign rise = wrap && !mdc;
    assign fall = wrap && mdc;

    // clock parks low between frames so each frame starts on a full low half
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            mdc <= 1'b0;
        end else if (!run) begin
            cnt <= '0;
            mdc <= 1'b0;
        end else if (wrap) begin
            cnt <= '0;
            mdc <= !mdc;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end

endmodule

// ### hdl/pms_ctrl.sv
// phy management serial controller: command register, framing, mdc and mdio
`timescale 1ns/1ps

// How it works
// - one 32-bit command register sits at offset 10h
// - writes may be 32-bit, two 16-bit or four 8-bit pieces
// - the assembled command is captured only when byte 13h is written
// - bits 31:30 always read as zero
// - with bit 29 set, each completed transfer raises the interrupt
// - bit 28 ready is set when a transfer has completed
// - opcode 01 writes, 10 reads; 00 and 11 are not used
// - phy address from bits 25:21, register number from bits 20:16
// - bits 15:0 carry write data out and read data back
// - write frame: preamble, 01, 01, addresses, 10, data, idle
// - read frame: preamble, 01, 10, addresses, then mdio released
// - first phy bit is dropped, next 16 bits stored as data
// - ready after the whole frame, in the same cycle read data is stored, or at once if the command write sets bit 28
// - mdc is generated here and never exceeds 2.5 MHz with the default MDC_HALF
// - device drives bits on mdc, samples phy bits on mdc
module pms_ctrl #(
    parameter int MDC_HALF = pms_pkg::MDC_HALF
) (
    input  wire logic                     clk,        // system clock, 40 MHz
    input  wire logic                     nrst,       // async reset, active low
    input  wire pms_pkg::pms_csr_req_type csr_req,    // register access request
    output logic [31:0]                   csr_rdata,  // read data, one cycle later
    output logic                          irq,        // transfer done interrupt
    output logic                          mdc,        // management clock to phy
    input  wire logic                     mdio_in,    // mdio pin level
    output logic                          mdio_out,   // mdio drive value
    output logic                          mdio_oe_n   // low while driving mdio
);

    pms_pkg::pms_cmd_type   cmd;
    pms_pkg::pms_cmd_type   stage;
    pms_pkg::pms_state_type state;
    pms_pkg::pms_state_type next_state;

    logic [63:0] shreg;
    logic [6:0]  bit_cnt;
    logic [15:0] rx_word;
    logic        is_read;
    logic        start_req;
    logic        mdio_s;
    logic        mdc_rise;
    logic        mdc_fall;

    // frame image, most significant bit leaves first
    function automatic logic [63:0] build_frame(input pms_pkg::pms_cmd_type c);
        logic [1:0] ta;
        ta = (c.op == pms_pkg::OP_READ) ? 2'h0 : pms_pkg::TA_PAT;
        build_frame = {pms_pkg::PREAMBLE, pms_pkg::START_PAT, c.op,
                       c.target_phy_sel, c.target_reg_sel, ta, c.data};
    endfunction

    function automatic logic [7:0] lane_pick(input logic       be,
                                             input logic [7:0] new_b,
                                             input logic [7:0] old_b);
        lane_pick = be ? new_b : old_b;
    endfunction

    // ---------------------------------------------------------------
    // register port decode
    // ---------------------------------------------------------------
    // word decode at 10h
    wire hit        = (csr_req.addr[7:2] == pms_pkg::CMD_OFS[7:2]);
    wire wr_hit     = csr_req.wr && hit;
    // capture on the top byte lane
    wire capture    = wr_hit && csr_req.be[pms_pkg::MSB_LANE];
    wire op_valid   = (cmd.op == pms_pkg::OP_WRITE) || (cmd.op == pms_pkg::OP_READ);

    // merge byte lanes into the staged word
    wire [31:0] merged = {
        lane_pick(csr_req.be[3], csr_req.wdata[31:24], stage[31:24]),
        lane_pick(csr_req.be[2], csr_req.wdata[23:16], stage[23:16]),
        lane_pick(csr_req.be[1], csr_req.wdata[15:8],  stage[15:8]),
        lane_pick(csr_req.be[0], csr_req.wdata[7:0],   stage[7:0])
    };
    wire pms_pkg::pms_cmd_type wr_cmd = merged;

    // ---------------------------------------------------------------
    // frame sequencing
    // ---------------------------------------------------------------
    wire in_shift   = (state == pms_pkg::ST_SHIFT);
    wire finishing  = (state == pms_pkg::ST_FINISH);
    wire begin_xfer = (state == pms_pkg::ST_IDLE) && start_req && op_valid;
    wire [6:0] frame_len = is_read ? pms_pkg::READ_BITS : pms_pkg::WRITE_BITS;
    wire last_fall  = in_shift && mdc_fall && (bit_cnt == frame_len - 7'h01);
    // slot after release is dropped, following 16 are kept
    wire rx_slot    = is_read && (bit_cnt > pms_pkg::READ_DRIVE)
                      && (bit_cnt < pms_pkg::READ_BITS);
    wire rx_take    = in_shift && mdc_rise && rx_slot;
    // release mdio once addresses are out on a read
    wire next_drive = (begin_xfer && !(cmd.op == pms_pkg::OP_READ && 1'b0))
                      || (in_shift && !last_fall
                          && !(is_read && mdc_fall
                               && bit_cnt == pms_pkg::READ_DRIVE - 7'h01)
                          && !mdio_oe_n);

    always_comb begin
        next_state = state;
        unique case (state)
            pms_pkg::ST_IDLE: begin
                if (begin_xfer) begin
                    next_state = pms_pkg::ST_SHIFT;
                end
            end
            pms_pkg::ST_SHIFT: begin
                if (last_fall) begin
                    next_state = pms_pkg::ST_FINISH;
                end
            end
            pms_pkg::ST_FINISH: begin
                next_state = pms_pkg::ST_IDLE;
            end
            default: begin
                next_state = pms_pkg::ST_IDLE;
            end
        endcase
    end

    // divided clock runs only while a frame is on the wire
    pms_mdc_gen #(
        .HALF (MDC_HALF)
    ) u_mdc (
        .clk  (clk),
        .nrst (nrst),
        .run  (in_shift),
        .mdc  (mdc),
        .rise (mdc_rise),
        .fall (mdc_fall)
    );

    // phy data enters through two flops before sampling
    pms_sync #(
        .WIDTH (1)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (mdio_in),
        .q    (mdio_s)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= pms_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // shifter: load on start, advance on mdc falling edge
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shreg   <= 64'h0;
            bit_cnt <= 7'h00;
            is_read <= 1'b0;
        end else if (begin_xfer) begin
            shreg   <= build_frame(cmd);
            bit_cnt <= 7'h00;
            is_read <= (cmd.op == pms_pkg::OP_READ);
        end else if (in_shift && mdc_fall) begin
            // new bit goes out after the falling edge
            shreg   <= {shreg[62:0], 1'b1};
            bit_cnt <= bit_cnt + 7'h01;
        end
    end

    // idle between frames parks the line released
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mdio_oe_n <= 1'b1;
        end else begin
            mdio_oe_n <= !next_drive;
        end
    end

    assign mdio_out = shreg[63];

    // phy bits arrive msb first after its leading zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_word <= 16'h0000;
        end else if (rx_take) begin
            rx_word <= {rx_word[14:0], mdio_s};
        end
    end

    // ---------------------------------------------------------------
    // command register
    // ---------------------------------------------------------------
    // staging keeps the low lanes until the top byte arrives
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage <= pms_pkg::CMD_RESET;
        end else if (wr_hit) begin
            stage <= merged;
        end
    end

    // a new capture only queues; the shifter keeps its own copy
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_req <= 1'b0;
        end else if (capture) begin
            start_req <= 1'b1;
        end else if (begin_xfer) begin
            start_req <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd <= pms_pkg::CMD_RESET;
        end else begin
            cmd.rsvd <= 2'h0;
            if (capture) begin
                cmd.done_irq_enable <= wr_cmd.done_irq_enable;
                cmd.op              <= wr_cmd.op;
                cmd.target_phy_sel  <= wr_cmd.target_phy_sel;
                cmd.target_reg_sel  <= wr_cmd.target_reg_sel;
                cmd.data            <= wr_cmd.data;
            end
            // read data lands in the data field
            if (finishing && is_read) begin
                cmd.data <= rx_word;
            end
            // completion sets ready; set wins over a clearing write
            if (finishing) begin
                cmd.ready <= 1'b1;
            end else if (capture) begin
                cmd.ready <= wr_cmd.ready;
            end
        end
    end

    // interrupt at completion when enabled, held until next command
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else if (finishing && cmd.done_irq_enable) begin
            irq <= 1'b1;
        end else if (capture) begin
            irq <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read port; unmapped offsets return zero
    // ---------------------------------------------------------------
    // reserved field forced to zero
    wire [31:0] rd_word = hit ? {2'h0, cmd[29:0]} : 32'h0000_0000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            csr_rdata <= 32'h0000_0000;
        end else if (csr_req.rd) begin
            csr_rdata <= rd_word;
        end
    end

endmodule

// ### sim/pms_ctrl_props.sv
// port checker for the phy management controller
`timescale 1ns/1ps
module pms_ctrl_props #(
    parameter int MDC_HALF = 8
) (
    input wire logic                     clk,       // clock
    input wire logic                     nrst,      // reset
    input wire pms_pkg::pms_csr_req_type csr_req,   // request
    input wire logic [31:0]              csr_rdata, // read data
    input wire logic                     irq,       // done irq
    input wire logic                     mdc,       // link clock
    input wire logic                     mdio_in,   // pin level
    input wire logic                     mdio_out,  // drive value
    input wire logic                     mdio_oe_n  // drive enable
);
    logic       mdc_q;
    logic       ie_q;
    logic [7:0] run;
    logic [6:0] rises;
    wire        cap = csr_req.wr && csr_req.be[3] && csr_req.addr[7:2] == 6'h04;
    wire  [1:0] op  = csr_req.wdata[27:26];
    wire        idle = mdio_oe_n && !mdc;
    // run saturates so a long idle never wraps into a short level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mdc_q <= 1'b0;
            ie_q  <= 1'b0;
            run   <= 8'h00;
            rises <= 7'h00;
        end else begin
            mdc_q <= mdc;
            ie_q  <= cap ? csr_req.wdata[29] : ie_q;
            run   <= (mdc != mdc_q) ? 8'h01 : ((run == 8'hFF) ? run : run + 8'h01);
            rises <= mdio_oe_n ? 7'h00 : rises + {6'h00, mdc & ~mdc_q};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_cap_op;
        cap && (op == pms_pkg::OP_WRITE || op == pms_pkg::OP_READ) && idle;
    endsequence
    sequence s_first_bit;
        !mdio_oe_n && mdio_out && !mdc;
    endsequence
    chk_rsvd_zero: assert property (csr_rdata[31:30] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_unmapped_read: assert property (
        csr_req.rd && csr_req.addr[7:2] != 6'h04 |=> csr_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_mdc_rate: assert property ((mdc != mdc_q) |-> run >= MDC_HALF)
        else $error("mdc level too short");
    chk_frame_start: assert property (s_cap_op |-> ##[1:6] s_first_bit)
        else $error("frame did not start");
    chk_reserved_idle: assert property (
        cap && (op == 2'h0 || op == 2'h3) && idle |=> mdio_oe_n [*8])
        else $error("reserved opcode drove mdio");
    chk_frame_len: assert property ($rose(mdio_oe_n) |->
        rises == pms_pkg::READ_DRIVE || rises == pms_pkg::WRITE_BITS)
        else $error("wrong count of driven bits");
    chk_preamble_ones: assert property (!mdio_oe_n && rises < 7'h20 |-> mdio_out)
        else $error("preamble bit not one");
    chk_bit_timing: assert property (
        !mdio_oe_n && !$past(mdio_oe_n) && $changed(mdio_out) |-> $fell(mdc))
        else $error("mdio changed away from mdc fall");
    chk_irq_done: assert property ($rose(irq) |-> ie_q && idle)
        else $error("irq raised out of place");
    chk_irq_clear: assert property (cap |-> ##[1:3] !irq)
        else $error("irq kept over new command");
endmodule

bind pms_ctrl pms_ctrl_props #(.MDC_HALF(MDC_HALF)) pms_ctrl_props_i (.clk(clk),
    .nrst(nrst), .csr_req(csr_req), .csr_rdata(csr_rdata), .irq(irq), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));

// ### sim/pms_phy_model.sv
// behavioural phy on the far side of the management link
`timescale 1ns/1ps
module pms_phy_model (
    input  wire logic        mdc,    // link clock
    input  wire logic        mdio,   // resolved line
    input  wire logic        clear,  // restart capture
    input  wire logic [15:0] rdata,  // word for reads
    output logic             drv,    // phy drives line
    output logic             dout,   // phy drive value
    output logic [63:0]      frame,  // sampled bits
    output logic [6:0]       nbits   // sampled count
);
    always @(posedge mdc or posedge clear) begin
        if (clear) begin
            frame <= 64'h0;
            nbits <= 7'h00;
        end else begin
            frame <= {frame[62:0], mdio};
            nbits <= nbits + 7'h01;
        end
    end
    // zero, then data msb first, changed on mdc fall
    always @(negedge mdc or posedge clear) begin
        if (clear) begin
            drv  <= 1'b0;
            dout <= 1'b0;
        end else if (nbits == 7'h2E && frame[11:10] == 2'h2) begin
            drv  <= 1'b1;
            dout <= 1'b0;
        end else if (drv && nbits < 7'h3F) begin
            dout <= rdata[7'h3E - nbits];
        end else begin
            drv  <= 1'b0;
        end
    end
endmodule

// ### sim/pms_ctrl_bench.sv
// self-checking bench for the phy management controller
`timescale 1ns/1ps
module pms_ctrl_bench;
    localparam int HALF = 4;
    logic                     clk = 1'b0;
    logic                     nrst = 1'b0;
    logic                     clr = 1'b0;
    pms_pkg::pms_csr_req_type req = '0;
    logic [31:0]              rdata;
    logic                     irq, mdc, mdo, oe_n, drv, dout;
    logic [15:0]              phy_word = 16'h0000;
    logic [63:0]              frame;
    logic [6:0]               nbits;
    logic [31:0]              seed = 32'h45F6;
    int                       bad_count = 0;
    int                       check_count = 0;
    // released line floats to the pull-up
    wire                      mdio = !oe_n ? mdo : (drv ? dout : 1'b1);

    pms_ctrl #(.MDC_HALF(HALF)) pms_ctrl_i (.clk(clk), .nrst(nrst), .csr_req(req),
        .csr_rdata(rdata), .irq(irq), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdo),
        .mdio_oe_n(oe_n));
    pms_phy_model pms_phy_model_i (.mdc(mdc), .mdio(mdio), .clear(clr),
        .rdata(phy_word), .drv(drv), .dout(dout), .frame(frame), .nbits(nbits));

    always #12.5 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [63:0] exp_frame(input logic [31:0] c, input logic [15:0] w);
        if (c[27:26] == 2'h2)
            return {1'b0, 32'hFFFF_FFFF, 2'h1, c[27:16], 1'b0, w};
        return {32'hFFFF_FFFF, 2'h1, c[27:16], 2'h2, c[15:0]};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string s);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    // lanes left out of the access carry inverted junk
    task automatic wr(input logic [7:0] a, input logic [3:0] en, input logic [31:0] d);
        logic [31:0] m;
        m = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, be: en, wdata: ~(d ^ m)};
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge clk);
        #1 req.rd = 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic wait_ready(output logic [31:0] d);
        for (int i = 0; i < 400; i++) begin
            rd(8'h10, d);
            if (d[28] === 1'b1)
                return;
        end
        check(0, 1, "ready timeout");
    endtask
    // whole word, two halves or four bytes, top byte always last
    task automatic issue(input logic [31:0] c, input int m);
        clr = 1'b1;
        #1 clr = 1'b0;
        if (m == 0)
            wr(8'h10, 4'hF, c);
        else if (m == 1) begin
            wr(8'h10, 4'h3, c);
            wr(8'h12, 4'hC, c);
        end else
            for (int i = 0; i < 4; i++)
                wr(8'h10 + 8'(i), 4'h1 << i, c);
    endtask

    initial begin
        logic [31:0] c;
        logic [31:0] d;
        // a real edge on clear so the phy model leaves its unknown start state
        #1 clr = 1'b1;
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        clr = 1'b0;
        rd(8'h10, d);
        check(d, pms_pkg::CMD_RESET, "reset value");
        check({irq, mdc, oe_n}, 3'h1, "idle pins");
        wr(8'h14, 4'hF, 32'h0800_1234);
        rd(8'h14, d);
        check(d, 32'h0, "unmapped read");
        // opcodes 00 and 11, then a read command staged without its top byte
        for (int k = 0; k < 3; k++) begin
            wr(8'h10, (k == 2) ? 4'h7 : 4'hF, {4'h2, 2'(k * 3), 26'h3FF_FFFF});
            repeat (100) @(posedge clk);
            check(nbits, 0, "no frame expected");
        end
        for (int n = 0; n < 9; n++) begin
            c = xs();
            c[27:26] = n[0] ? pms_pkg::OP_READ : pms_pkg::OP_WRITE;
            c[28] = 1'b0;
            if (n < 2)
                c[25:16] = n[0] ? 10'h3FF : 10'h000;
            phy_word = (n == 3) ? 16'hFFFF : 16'(xs());
            issue(c, n % 3);
            wait_ready(d);
            check(frame, exp_frame(c, phy_word), "frame bits");
            check(d, {2'h0, c[29], 1'b1, c[27:16], c[27] ? phy_word : c[15:0]},
                "command word");
            check(irq, c[29], "done irq");
        end
        stop_test();
    end

    initial begin
        #1_000_000;
        bad_count++;
        stop_test();
    end
endmodule
